// ==== ctmr_dev.sv ====
// Purpose: Clock timer with 8-bit count, run control, four tick interrupts.
// Assumes: Bus strobes one cycle long and synchronous to CLOCK_I.
// Notes:   The 256 Hz signal is a square wave built from enable pulses.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
`include "ctmr_map.svh"
module ctmr_dev #(
  parameter int unsigned HALF_DIV = `CTMR_HALF_DIV
) (
  input  wire logic CLOCK_I,
  input  wire logic SYS_RST_I,
  input  wire logic OSC_ON_I,
  output logic      TICK_256_O,
  ctmr_if.dev       bus
);

  // Last divider count of a half period, cut to the divider's width on purpose.
  localparam logic [31:0] half_last = 32'(HALF_DIV - 1);

  // Divider state and the 256 Hz square wave.
  logic [31:0]          div_q;
  logic [31:0]          div_d;
  logic                 half_pulse;
  logic                 sq256_q;
  logic                 tick_fall;

  // Software visible state.
  logic                 run_req_q;
  logic                 run_d;
  logic                 run_act_q;
  ctmr_pkg::ctmr_byte_t cnt_q;
  ctmr_pkg::ctmr_byte_t cnt_d;
  ctmr_pkg::ctmr_src_t  mask_q;
  ctmr_pkg::ctmr_src_t  flag_q;
  ctmr_pkg::ctmr_src_t  flag_clr;
  ctmr_pkg::ctmr_src_t  flag_d;
  ctmr_pkg::ctmr_byte_t rdata_q;
  ctmr_pkg::ctmr_byte_t rdata_d;

  // Decoded accesses.
  logic                 wr_ctrl;
  logic                 wr_mask;
  logic                 wr_flag;
  logic                 clear_cnt;
  logic                 advance;
  ctmr_pkg::ctmr_byte_t cnt_next;
  ctmr_pkg::ctmr_src_t  src_fall;
  ctmr_pkg::ctmr_byte_t rd_value;

  // True when an access hits the given register offset.
  function automatic logic hit(input ctmr_pkg::ctmr_addr_t a, input ctmr_pkg::ctmr_addr_t ofs);
    hit = (a == ofs);
  endfunction

  // Picks the four interrupt sources out of a count value, 32 Hz in bit 3.
  function automatic ctmr_pkg::ctmr_src_t sources(input ctmr_pkg::ctmr_byte_t c);
    sources = {c[`CTMR_CNT_32HZ], c[`CTMR_CNT_8HZ], c[`CTMR_CNT_2HZ], c[`CTMR_CNT_1HZ]};
  endfunction

  // Next divider count. Holding it at zero while the slow oscillator is off makes the
  // first half period after a restart full length; the partial period already counted
  // is given up for that, so the first tick after a restart may come up to a half period late.
  always_comb begin
    div_d = div_q + 32'h0000_0001;
    if (!OSC_ON_I || half_pulse) begin
      div_d = 32'h0000_0000;
    end
  end

  // Half period divider; it is held at zero while the slow oscillator is off.
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      div_q <= 32'h0000_0000;
    end else begin
      div_q <= div_d;
    end
  end

  assign half_pulse = OSC_ON_I && (div_q == half_last);

  // The square wave toggles every half period; the counter works on its falling edge.
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      sq256_q <= 1'b0;
    end else if (half_pulse) begin
      sq256_q <= ~sq256_q;
    end
  end

  assign tick_fall  = half_pulse && sq256_q;
  assign TICK_256_O = sq256_q;

  // Register decode. Writes outside the map are dropped silently.
  assign wr_ctrl   = bus.wr && hit(bus.addr, `CTMR_OFS_CONTROL);
  assign wr_mask   = bus.wr && hit(bus.addr, `CTMR_OFS_MASK);
  assign wr_flag   = bus.wr && hit(bus.addr, `CTMR_OFS_FLAGS);
  assign clear_cnt = wr_ctrl && bus.wdata[`CTMR_BIT_CLEAR];

  // Next run request; only a control write changes it, and control reads it ORed with the active run state.
  // A stop request still waits for a tick fall, so with the oscillator off it never lands.
  always_comb begin
    run_d = run_req_q;
    if (wr_ctrl) begin
      run_d = bus.wdata[`CTMR_BIT_RUN];
    end
  end

  // The run request is what software wrote.
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      run_req_q <= 1'b0;
    end else begin
      run_req_q <= run_d;
    end
  end

  // The request is only obeyed on a falling tick edge, so a stop still lets one increment through.
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      run_act_q <= 1'b0;
    end else if (tick_fall) begin
      run_act_q <= run_req_q;
    end
  end

  assign advance  = tick_fall && run_act_q;
  assign cnt_next = cnt_q + 8'h01;

  // Next count; clear wins over an increment in the same cycle, though that increment's source edges still reach the flags.
  always_comb begin
    cnt_d = cnt_q;
    if (clear_cnt) begin
      cnt_d = `CTMR_RST_BYTE;
    end else if (advance) begin
      cnt_d = cnt_next;
    end
  end

  // Binary up-counter register.
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      cnt_q <= `CTMR_RST_BYTE;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  // A stopped counter simply sees no advance and keeps its value.

  // A source falls when its count bit goes from one to zero on an increment.
  assign src_fall = advance ? (sources(cnt_q) & ~sources(cnt_next)) : 4'h0;

  // Interrupt enables; reserved bits are not stored.
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      mask_q <= 4'h0;
    end else if (wr_mask) begin
      mask_q <= bus.wdata[3:0];
    end
  end

  // Next flags: the write-one clear is applied first and new events are ORed on top,
  // so an event and its clear in the same cycle leave the flag set and nothing is lost.
  always_comb begin
    flag_clr = wr_flag ? bus.wdata[3:0] : 4'h0;
    flag_d   = (flag_q & ~flag_clr) | (src_fall & mask_q);
  end

  // Sticky flags.
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      flag_q <= 4'h0;
    end else begin
      flag_q <= flag_d;
    end
  end

  // The shared request follows the flags, so it rises with the flag itself.
  assign bus.irq = |flag_q;

  // Read mux; the clear bit and all reserved bits read zero. The count is taken straight
  // from its register, so a read while running is always a settled value, though portable
  // software should still stop the counter or read it twice.
  always_comb begin
    rd_value = `CTMR_RST_BYTE;
    unique case (bus.addr)
      `CTMR_OFS_CONTROL: rd_value = {7'h00, run_req_q | run_act_q};
      `CTMR_OFS_COUNT:   rd_value = cnt_q;
      `CTMR_OFS_MASK:    rd_value = {4'h0, mask_q};
      `CTMR_OFS_FLAGS:   rd_value = {4'h0, flag_q};
      default:           rd_value = `CTMR_RST_BYTE;
    endcase
  end

  // Read data are zero outside their slot, so a late sample never looks like a register.
  always_comb begin
    rdata_d = `CTMR_RST_BYTE;
    if (bus.rd) begin
      rdata_d = rd_value;
    end
  end

  // Read data stand for exactly the cycle after the strobe.
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      rdata_q <= `CTMR_RST_BYTE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // The count register ignores writes entirely since it is never decoded for writing.
  assign bus.rdata = rdata_q;

endmodule // ctmr_dev

// ==== ctmr_map.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the clock timer.
// Assumes: Included by its bare name from both ends of the clock timer link.
// Notes:   Definitions only.
//
// Summary of operation
// - All registers eight bits, reserved reads zero.
// - Software writes zero into reserved bits.
// - Writing one to bit 4 clears counter.
// - Cleared counter resumes if running, else holds.
// - Bit 0 run control, reset stopped.
// - Stopped counter holds its value.
// - Counter register read only, full range.
// - Bit 0 toggles 128 Hz, halving upward.
// - Software stops or double reads the counter.
// - Mask holds four enables, reset disabled.
// - Flag sets on enabled source falling edge.
// - Request driven in flag setting cycle.
// - Flags clear by writing one, reset zero.
// - Controller level triggered, cleared via block flag.
// - Software clears flags before enabling them.
// - Controller enable also needed for interrupts.
// - 256 Hz tick advances counter, reset clears.
// - Run and stop act at tick edge.
// - One shared request while any flag set.
`ifndef CTMR_MAP_SVH
`define CTMR_MAP_SVH

`define CTMR_OFS_CONTROL   16'h5000
`define CTMR_OFS_COUNT     16'h5001
`define CTMR_OFS_MASK      16'h5002
`define CTMR_OFS_FLAGS     16'h5003
`define CTMR_OFS_HOST_EN   16'h0010
`define CTMR_OFS_HOST_FLG  16'h0011

`define CTMR_BIT_RUN       0
`define CTMR_BIT_CLEAR     4
`define CTMR_MASK_BITS     8'h0F
`define CTMR_CTRL_BITS     8'h11

`define CTMR_RST_BYTE      8'h00

`define CTMR_CNT_32HZ      2
`define CTMR_CNT_8HZ       4
`define CTMR_CNT_2HZ       6
`define CTMR_CNT_1HZ       7

`define CTMR_CLK_HZ        50000000
`define CTMR_TICK_HZ       256
`define CTMR_HALF_DIV      (`CTMR_CLK_HZ / (2 * `CTMR_TICK_HZ))

`endif

// ==== ctmr_pkg.sv ====
// Purpose: Types shared by both ends of the clock timer.
// Assumes: Nothing beyond the map header for numbers.
// Notes:   Holds types only.
package ctmr_pkg;
  typedef logic [7:0]  ctmr_byte_t;
  typedef logic [15:0] ctmr_addr_t;
  typedef logic [3:0]  ctmr_src_t;
endpackage

// ==== ctmr_if.sv ====
// Purpose: Register bus and interrupt request between clock timer and its controller.
// Assumes: One clock; read data stand the cycle after the read strobe.
// Notes:   The host modport masters the bus and receives the request.
`timescale 1ns/1ps
interface ctmr_if;
  ctmr_pkg::ctmr_addr_t addr;
  ctmr_pkg::ctmr_byte_t wdata;
  logic                 wr;
  logic                 rd;
  ctmr_pkg::ctmr_byte_t rdata;
  logic                 irq;

  modport dev  (input addr, input wdata, input wr, input rd, output rdata, output irq);
  modport host (output addr, output wdata, output wr, output rd, input rdata, input irq);
endinterface

// ==== ctmr_host.sv ====
// Purpose: Interrupt controller slot and bus master facing the clock timer.
// Assumes: Software port strobes are one cycle long and never overlap.
// Notes:   Timer offsets pass through; two offsets are local to this end.
`timescale 1ns/1ps
`include "ctmr_map.svh"
module ctmr_host (
  input  wire logic                 CLOCK_I,
  input  wire logic                 SYS_RST_I,
  input  wire ctmr_pkg::ctmr_addr_t SW_ADDR_I,
  input  wire ctmr_pkg::ctmr_byte_t SW_WDATA_I,
  input  wire logic                 SW_WR_I,
  input  wire logic                 SW_RD_I,
  output ctmr_pkg::ctmr_byte_t      SW_RDATA_O,
  output logic                      CPU_IRQ_O,
  ctmr_if.host                      bus
);

  logic                 en_q;
  logic                 local_rd_q;
  ctmr_pkg::ctmr_byte_t local_q;
  ctmr_pkg::ctmr_byte_t wmask;

  // Reserved bits are forced to zero on the way out.
  always_comb begin
    wmask = 8'hFF;
    unique case (SW_ADDR_I)
      `CTMR_OFS_CONTROL: wmask = `CTMR_CTRL_BITS;
      `CTMR_OFS_MASK:    wmask = `CTMR_MASK_BITS;
      `CTMR_OFS_FLAGS:   wmask = `CTMR_MASK_BITS;
      default:           wmask = 8'hFF;
    endcase
  end

  assign bus.addr  = SW_ADDR_I;
  assign bus.wdata = SW_WDATA_I & wmask;
  assign bus.wr    = SW_WR_I;
  assign bus.rd    = SW_RD_I;

  // Controller enable bit of this source.
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      en_q <= 1'b0;
    end else if (SW_WR_I && SW_ADDR_I == `CTMR_OFS_HOST_EN) begin
      en_q <= SW_WDATA_I[0];
    end
  end

  // Local reads; the pending flag is the request level, so clearing the timer flag clears it too.
  always_ff @(posedge CLOCK_I or posedge SYS_RST_I) begin
    if (SYS_RST_I) begin
      local_q    <= `CTMR_RST_BYTE;
      local_rd_q <= 1'b0;
    end else begin
      local_rd_q <= SW_RD_I && (SW_ADDR_I == `CTMR_OFS_HOST_EN || SW_ADDR_I == `CTMR_OFS_HOST_FLG);
      local_q    <= (SW_ADDR_I == `CTMR_OFS_HOST_EN) ? {7'h00, en_q} : {7'h00, bus.irq};
    end
  end

  // Level triggered: the processor sees the request only while enabled here.
  assign CPU_IRQ_O  = bus.irq & en_q;
  assign SW_RDATA_O = local_rd_q ? local_q : bus.rdata;

endmodule // ctmr_host

// ==== ctmr_props.sv ====
// Purpose: Checks on the bus and request line between the two timer ends.
// Assumes: One clock domain and an active high reset.
// Notes:   Instantiated beside the interface, no bind.
`timescale 1ns/1ps
module ctmr_props (
  input wire logic                 CLOCK_I,
  input wire logic                 SYS_RST_I,
  input wire ctmr_pkg::ctmr_addr_t addr,
  input wire ctmr_pkg::ctmr_byte_t wdata,
  input wire logic                 wr,
  input wire logic                 rd,
  input wire ctmr_pkg::ctmr_byte_t rdata,
  input wire logic                 irq
);
  // All checks share one clock, so clock and reset are stated once.
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SYS_RST_I);

  // Read data stand one cycle only and reserved bits read as zero.
  rdata_idle_a: assert property (!$past(rd) |-> rdata == 8'h00)
    else $error("read data seen outside the read slot");
  ctrl_read_a: assert property (rd && addr == 16'h5000 |=> rdata[7:1] == 7'h00)
    else $error("control read shows clear or reserved bits");
  mask_read_a: assert property (rd && addr == 16'h5002 |=> rdata[7:4] == 4'h0)
    else $error("mask read shows reserved bits");
  flag_read_a: assert property (rd && addr == 16'h5003 |=> rdata[7:4] == 4'h0)
    else $error("flag read shows reserved bits");
  unmapped_read_a: assert property (rd && (addr < 16'h5000 || addr > 16'h5003) |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  // The request line mirrors the flags; a flag seen set means a request stands.
  irq_shared_a: assert property (rd && addr == 16'h5003 ##1 rdata[3:0] != 4'h0 |-> irq)
    else $error("flag set without request");
  irq_idle_a: assert property (rd && addr == 16'h5003 && !irq |=> rdata[3:0] == 4'h0)
    else $error("request low with a flag set");
  irq_hold_a: assert property (irq && !(wr && addr == 16'h5003) |=> irq)
    else $error("request dropped without a flag write");

  cover property ($rose(irq));
  cover property (wr && addr == 16'h5000 && wdata == 8'h11);
  cover property (irq && wr && addr == 16'h5003);
endmodule // ctmr_props

// ==== clock_timer_registers_tb.sv ====
// Purpose: Self-checking bench of both timer ends against a queue-free model.
// Assumes: Divider shortened so a tick lasts eight clocks.
// Notes:   Bus work is done away from tick falls to keep the model exact.
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== ctmr_pkg::ctmr_byte_t'(e)) begin fail_count++; $display("wrong value %s exp %h got %h", n, e, g); end end
module clock_timer_registers_tb;
  logic                 clk = 1'b0, rst = 1'b1, osc = 1'b1, wr = 1'b0, rd = 1'b0;
  ctmr_pkg::ctmr_addr_t a = 16'h0000;
  ctmr_pkg::ctmr_byte_t wd = 8'h00, d, sw_rdata;
  logic                 cpu_irq, tick;
  int                   fail_count = 0, num_checks = 0, cnt = 0, act = 0, req = 0, msk = 0, flg = 0, hen = 0;
  int                   sb[4] = '{7, 6, 4, 2};

  // Free running system clock.
  always #10 clk = ~clk;

  ctmr_if lnk ();
  ctmr_dev #(.HALF_DIV(4)) u_ctmr_dev (.CLOCK_I(clk), .SYS_RST_I(rst), .OSC_ON_I(osc), .TICK_256_O(tick), .bus(lnk));
  ctmr_host u_ctmr_host (.CLOCK_I(clk), .SYS_RST_I(rst), .SW_ADDR_I(a), .SW_WDATA_I(wd), .SW_WR_I(wr),
    .SW_RD_I(rd), .SW_RDATA_O(sw_rdata), .CPU_IRQ_O(cpu_irq), .bus(lnk));
  ctmr_props u_ctmr_props (.CLOCK_I(clk), .SYS_RST_I(rst), .addr(lnk.addr), .wdata(lnk.wdata), .wr(lnk.wr),
    .rd(lnk.rd), .rdata(lnk.rdata), .irq(lnk.irq));

  // One write cycle, then the model takes the same effect.
  task automatic wr_reg(input ctmr_pkg::ctmr_addr_t ad, input int v);
    @(posedge clk); a <= ad; wd <= v[7:0]; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
    case (ad)
      16'h5000: begin if (v[4]) cnt = 0; req = v & 1; end
      16'h5002: msk = v & 15;
      16'h5003: flg &= ~v;
      16'h0010: hen = v & 1;
      default: ;
    endcase
  endtask

  // One read cycle; the data are taken once the next edge has landed.
  task automatic rd_chk(input ctmr_pkg::ctmr_addr_t ad, input int e, input string n);
    @(posedge clk); a <= ad; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 d = sw_rdata;
    `CHK(n, e, d)
  endtask

  // Waits for a tick fall and advances the model; run or stop acts here.
  task automatic step;
    int o;
    @(negedge tick);
    o = cnt;
    if (act) begin
      cnt = (cnt + 1) % 256;
      for (int i = 0; i < 4; i++) if (o[sb[i]] && !cnt[sb[i]] && msk[i]) flg |= 1 << i;
    end
    act = req;
    repeat (2) @(posedge clk);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  // Main sequence.
  initial begin
    void'($urandom(32'he2ac));
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 4; i++) rd_chk(16'h5000 + i[15:0], 0, "reset value");
    wr_reg(16'h5001, $urandom & 255);
    rd_chk(16'h5001, 0, "count after write");
    rd_chk(16'h5004, 0, "unmapped");
    wr_reg(16'h5003, 15);
    for (int i = 0; i < 4; i++) begin
      wr_reg(16'h5002, i == 0 ? 15 : $urandom & 15);
      rd_chk(16'h5002, msk, "mask");
    end
    $display("test registers done");
    wr_reg(16'h5003, 15);
    wr_reg(16'h0010, 1);
    step();
    wr_reg(16'h5000, 8'h11);
    for (int t = 0; t < 300; t++) begin
      step();
      case (t % 4)
        0: begin
          rd_chk(16'h5001, cnt, "count"); rd_chk(16'h5003, flg, "flags");
          `CHK("tick", 1, tick)
        end
        1: begin wr_reg(16'h5003, $urandom & 15); rd_chk(16'h5000, req | act, "control"); end
        2: begin
          wr_reg(16'h0010, $urandom & 1);
          rd_chk(16'h0011, flg != 0, "pending");
          `CHK("cpu irq", (flg != 0) && hen, cpu_irq)
        end
        default: if (t % 64 == 3) wr_reg(16'h5002, $urandom & 15); else rd_chk(16'h5001, cnt, "count");
      endcase
    end
    $display("test run done");
    step();
    wr_reg(16'h5000, 0);
    rd_chk(16'h5000, 1, "stopping");
    step();
    rd_chk(16'h5001, cnt, "last count");
    step();
    step();
    rd_chk(16'h5001, cnt, "held count");
    rd_chk(16'h5000, 0, "stopped");
    wr_reg(16'h5000, 8'h10);
    step();
    rd_chk(16'h5001, 0, "cleared stopped");
    wr_reg(16'h5000, 1);
    repeat (3) step();
    rd_chk(16'h5001, cnt, "restart");
    step();
    wr_reg(16'h5000, 8'h11);
    rd_chk(16'h5001, 0, "cleared running");
    repeat (2) step();
    rd_chk(16'h5001, cnt, "resumed");
    // With the oscillator off the tick and the running count must freeze.
    @(posedge clk); osc <= 1'b0;
    repeat (40) @(posedge clk);
    rd_chk(16'h5001, cnt, "frozen");
    `CHK("tick frozen", 1, tick)
    @(posedge clk); osc <= 1'b1;
    repeat (2) step();
    rd_chk(16'h5001, cnt, "thawed");
    // A second reset in mid-run must bring every register back to its reset value.
    @(posedge clk); rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    cnt = 0; act = 0; req = 0; msk = 0; flg = 0; hen = 0;
    for (int i = 0; i < 4; i++) rd_chk(16'h5000 + i[15:0], 0, "reset again");
    rd_chk(16'h0010, 0, "host enable reset");
    $display("test stop and clear done");
    give_verdict();
  end
endmodule // clock_timer_registers_tb
